// file: core/mdts_core.sv
/*
  timebase and trigger synchronisation core with an ahb-lite register slave.
  assumes: one hclk domain; all timebase, reference and trigger inputs are
  already synchronous to hclk and given as one-cycle edge ticks or levels.
*/
`include "mdts_consts.svh"

// Behaviour
// RULE1: accept slow or fast backplane reference
// RULE2: cable reference selectable per task
// RULE3: master locks pll to onboard oscillator
// RULE4: slave replaces oscillator with received timebase
// RULE5: programmed main timebase rate used
// RULE6: substitute master sample timebase
// RULE7: sample timebase divides from programmed rate
// RULE8: derived clocks start on common trigger
// RULE9: host arms slaves before master
// RULE10: pll may lock to main timebase
// RULE11: counter timebase from shared terminal
// RULE12: counter gate may be sample clock
// RULE13: shared output timebase and start trigger
// RULE14: master reacts to and exports trigger
// RULE15: skew correction waits for reference edge
// RULE16: implicit start trigger when task starts
// RULE17: pll locks onboard oscillator to reference
// RULE18: selections change only while idle
module mdts_core #(
  parameter int RATE_W = 32,
  parameter logic [15:0] LOCK_CYCLES = `MDTS_LOCK_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic onboard_tick,
  input wire logic backplane_ref_clock_slow,
  input wire logic backplane_ref_clock_fast,
  input wire logic exported_reference_clock,
  input wire logic main_timebase_in,
  input wire logic sample_timebase_in,
  input wire logic fast_internal_timebase,
  input wire logic counter_gate_signal,
  input wire logic ext_sample_clock,
  input wire logic cable_trigger_bus,
  output logic pll_ref_tick,
  output logic main_timebase_tick,
  output logic sample_clock,
  output logic counter_timebase,
  output logic counter_sample_clock,
  output logic start_trigger,
  output logic trigger_out,
  output logic pll_locked,
  output logic task_running
);
  import mdts_pkg::*;
  // ----------------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------------
  logic is_master;
  logic skew_corr;
  logic ext_trig_en;
  mdts_ref_type ref_sel;
  logic main_ext;
  logic samp_ext;
  logic [RATE_W-1:0] main_rate;
  logic [RATE_W-1:0] samp_rate;
  logic [RATE_W-1:0] samp_div;
  logic ctr_tb_shared;
  logic ctr_gate_clk;
  mdts_task_type task_state;
  logic start_req;
  logic stop_req;
  logic [15:0] lock_count;
  logic ref_tick;
  logic trig_pending;
  logic trig_fire;
  logic tb_tick;
  logic samp_tb_tick;
  logic div_pulse;
  logic [RATE_W-1:0] next_period;

  // ----------------------------------------------------------------------------
  // ahb-lite data phase capture
  // ----------------------------------------------------------------------------
  logic dp_valid;
  logic dp_write;
  logic [11:0] dp_addr;
  logic idle;
  logic wr_ctrl;

  assign idle = (task_state == MDTS_IDLE);
  assign wr_ctrl = dp_valid && dp_write && dp_addr == `MDTS_OFF_CTRL;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 12'h000;
    end else if (hready) begin
      dp_valid <= hsel && htrans[1];
      dp_write <= hwrite;
      dp_addr <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // configuration writes, accepted only while idle
  // ----------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      is_master <= 1'b0;
      skew_corr <= 1'b0;
      ext_trig_en <= 1'b0;
      ref_sel <= MDTS_REF_ONBOARD;
      main_ext <= 1'b0;
      samp_ext <= 1'b0;
      main_rate <= RATE_W'(`MDTS_RST_MAIN_RATE);
      samp_rate <= RATE_W'(`MDTS_RST_SAMP_RATE);
      samp_div <= RATE_W'(`MDTS_RST_SAMP_DIV);
      ctr_tb_shared <= 1'b0;
      ctr_gate_clk <= 1'b0;
    end else if (dp_valid && dp_write && idle) begin // RULE18
      unique case (dp_addr)
        `MDTS_OFF_CTRL: begin
          is_master <= hwdata[`MDTS_CTRL_MASTER];
          skew_corr <= hwdata[`MDTS_CTRL_SKEW];
          ext_trig_en <= hwdata[`MDTS_CTRL_EXT_TRIG];
        end
        `MDTS_OFF_SRC: begin
          if (hwdata[2:0] <= 3'd4) begin
            ref_sel <= mdts_ref_type'(hwdata[2:0]); // RULE2
          end
          main_ext <= hwdata[`MDTS_SRC_MAIN_BIT]; // RULE4
          samp_ext <= hwdata[`MDTS_SRC_SAMP_BIT]; // RULE6
        end
        `MDTS_OFF_MAIN_RATE: main_rate <= hwdata[RATE_W-1:0]; // RULE5
        `MDTS_OFF_SAMP_RATE: samp_rate <= hwdata[RATE_W-1:0]; // RULE7
        `MDTS_OFF_SAMP_DIV: samp_div <= hwdata[RATE_W-1:0];
        `MDTS_OFF_CTR_SEL: begin
          ctr_tb_shared <= hwdata[0]; // RULE11
          ctr_gate_clk <= hwdata[1]; // RULE12
        end
        default: ;
      endcase
    end
  end

  assign start_req = wr_ctrl && hwdata[`MDTS_CTRL_START];
  assign stop_req = wr_ctrl && hwdata[`MDTS_CTRL_STOP];

  // ----------------------------------------------------------------------------
  // reference selection and lock tracking
  // ----------------------------------------------------------------------------
  always_comb begin
    unique case (ref_sel)
      MDTS_REF_ONBOARD: ref_tick = onboard_tick; // RULE3
      MDTS_REF_BP_SLOW: ref_tick = backplane_ref_clock_slow; // RULE1
      MDTS_REF_BP_FAST: ref_tick = backplane_ref_clock_fast; // RULE1
      MDTS_REF_CABLE: ref_tick = exported_reference_clock; // RULE2
      MDTS_REF_MAIN_TB: ref_tick = main_timebase_in; // RULE10
      default: ref_tick = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_ref_tick <= 1'b0;
      lock_count <= 16'h0000;
      pll_locked <= 1'b0;
    end else begin
      pll_ref_tick <= ref_tick; // RULE17
      if (ref_tick && lock_count != LOCK_CYCLES) begin
        lock_count <= lock_count + 16'h0001;
      end
      pll_locked <= (lock_count == LOCK_CYCLES);
    end
  end

  // ----------------------------------------------------------------------------
  // main and sample timebase choice
  // ----------------------------------------------------------------------------
  assign tb_tick = main_ext ? main_timebase_in : onboard_tick; // RULE4
  assign samp_tb_tick = samp_ext ? sample_timebase_in : tb_tick; // RULE6
  // divide count follows the programmed rate of the chosen external timebase; onboard uses samp_div alone
  assign next_period = samp_ext ? samp_rate / samp_div : // RULE7
                      (main_ext ? main_rate / samp_div : samp_div); // RULE5

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_timebase_tick <= 1'b0;
      counter_timebase <= 1'b0;
      counter_sample_clock <= 1'b0;
    end else begin
      main_timebase_tick <= tb_tick;
      counter_timebase <= ctr_tb_shared ? fast_internal_timebase : tb_tick; // RULE11 RULE13
      counter_sample_clock <= ctr_gate_clk ? counter_gate_signal : ext_sample_clock; // RULE12
    end
  end

  // ----------------------------------------------------------------------------
  // task state and start trigger
  // ----------------------------------------------------------------------------
  logic raw_trig;
  assign raw_trig = is_master ? (task_state == MDTS_ARMED) : // RULE16
                   (!ext_trig_en || cable_trigger_bus); // RULE9 RULE13

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_pending <= 1'b0;
    end else if (task_state != MDTS_ARMED) begin
      trig_pending <= 1'b0;
    end else if (raw_trig && skew_corr && !ref_tick) begin
      trig_pending <= 1'b1; // RULE15
    end
  end

  assign trig_fire = (task_state == MDTS_ARMED) &&
                     (skew_corr ? ((raw_trig || trig_pending) && ref_tick) : raw_trig); // RULE15

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      task_state <= MDTS_IDLE;
    end else begin
      unique case (task_state)
        MDTS_IDLE: if (start_req) task_state <= MDTS_ARMED;
        MDTS_ARMED: begin
          if (stop_req) task_state <= MDTS_IDLE;
          else if (trig_fire) task_state <= MDTS_RUN;
        end
        MDTS_RUN: if (stop_req) task_state <= MDTS_IDLE;
        default: task_state <= MDTS_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_trigger <= 1'b0;
      trigger_out <= 1'b0;
      task_running <= 1'b0;
    end else begin
      start_trigger <= trig_fire; // RULE14
      trigger_out <= trig_fire && is_master; // RULE14
      task_running <= (task_state == MDTS_RUN);
    end
  end

  // ----------------------------------------------------------------------------
  // sample clock divider
  // ----------------------------------------------------------------------------
  mdts_divider #(.WIDTH(RATE_W)) u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(samp_tb_tick),
    .sync(trig_fire),
    .run(task_state == MDTS_RUN),
    .period(next_period),
    .pulse(div_pulse)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_clock <= 1'b0;
    end else begin
      sample_clock <= div_pulse; // RULE8
    end
  end

  // ----------------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr)
        `MDTS_OFF_CTRL: hrdata <= {27'h0, ext_trig_en, skew_corr, is_master, 2'b00};
        `MDTS_OFF_SRC: hrdata <= {26'h0, samp_ext, main_ext, 1'b0, ref_sel};
        `MDTS_OFF_MAIN_RATE: hrdata <= 32'(main_rate);
        `MDTS_OFF_SAMP_RATE: hrdata <= 32'(samp_rate);
        `MDTS_OFF_SAMP_DIV: hrdata <= 32'(samp_div);
        `MDTS_OFF_CTR_SEL: hrdata <= {30'h0, ctr_gate_clk, ctr_tb_shared};
        `MDTS_OFF_STATUS: hrdata <= {29'h0, pll_locked, task_state};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  cfg_idle_only_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE18
    !idle |=> $stable(main_rate) && $stable(samp_rate) && $stable(ref_sel)) else $error("config changed while busy");
  master_start_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE16
    (task_state == MDTS_ARMED && is_master && !skew_corr && !stop_req) |=> task_state == MDTS_RUN)
    else $error("master did not start at once");
  trig_export_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE14
    trig_fire && is_master |=> trigger_out && start_trigger) else $error("trigger not exported");
  skew_wait_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE15
    start_trigger && skew_corr |-> pll_ref_tick) else $error("trigger not aligned");
  main_src_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE4
    main_ext |=> main_timebase_tick == $past(main_timebase_in)) else $error("main timebase wrong");
  ref_src_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE1
    ref_sel == MDTS_REF_BP_FAST |=> pll_ref_tick == $past(backplane_ref_clock_fast)) else $error("reference wrong");
  ctr_tb_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE11
    ctr_tb_shared |=> counter_timebase == $past(fast_internal_timebase)) else $error("counter timebase wrong");
  gate_clk_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE12
    ctr_gate_clk |=> counter_sample_clock == $past(counter_gate_signal)) else $error("gate clock wrong");
  slow_ref_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE1
    ref_sel == MDTS_REF_BP_SLOW |=> pll_ref_tick == $past(backplane_ref_clock_slow)) else $error("slow ref wrong");
  cable_ref_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE2
    ref_sel == MDTS_REF_CABLE |=> pll_ref_tick == $past(exported_reference_clock)) else $error("cable ref wrong");
  onboard_ref_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
    ref_sel == MDTS_REF_ONBOARD |=> pll_ref_tick == $past(onboard_tick)) else $error("onboard ref wrong");
  mixed_ref_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE10
    ref_sel == MDTS_REF_MAIN_TB |=> pll_ref_tick == $past(main_timebase_in)) else $error("mixed ref wrong");
  lock_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE17
    pll_locked |=> pll_locked) else $error("lock lost");
  slave_wait_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE13
    (task_state == MDTS_ARMED && !is_master && ext_trig_en && !cable_trigger_bus && !trig_pending && !stop_req)
    |=> task_state == MDTS_ARMED) else $error("slave started without trigger");
endmodule : mdts_core

// file: core/mdts_consts.svh
/*
  register offsets, field positions, reset values and timing counts of the
  timebase synchronisation block.
  assumes: included by the package and by the core; no other dependency.
*/
`ifndef MDTS_CONSTS_SVH
`define MDTS_CONSTS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define MDTS_OFF_CTRL 12'h000
`define MDTS_OFF_SRC 12'h004
`define MDTS_OFF_MAIN_RATE 12'h008
`define MDTS_OFF_SAMP_RATE 12'h00c
`define MDTS_OFF_SAMP_DIV 12'h010
`define MDTS_OFF_CTR_SEL 12'h014
`define MDTS_OFF_STATUS 12'h018

// ----------------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------------
`define MDTS_CTRL_START 0
`define MDTS_CTRL_STOP 1
`define MDTS_CTRL_MASTER 2
`define MDTS_CTRL_SKEW 3
`define MDTS_CTRL_EXT_TRIG 4

// ----------------------------------------------------------------------------
// source fields
// ----------------------------------------------------------------------------
`define MDTS_SRC_REF_LSB 0
`define MDTS_SRC_MAIN_BIT 4
`define MDTS_SRC_SAMP_BIT 5

// ----------------------------------------------------------------------------
// reset values and rates
// ----------------------------------------------------------------------------
`define MDTS_RATE_SLOW_HZ 32'd10000000
`define MDTS_RATE_FAST_HZ 32'd100000000
`define MDTS_RST_MAIN_RATE 32'd100000000
`define MDTS_RST_SAMP_RATE 32'd100000000
`define MDTS_RST_SAMP_DIV 32'd100
`define MDTS_LOCK_CYCLES 16'd64

`endif

// file: core/mdts_pkg.sv
/*
  types of the timebase synchronisation block.
  assumes: mdts_consts.svh is reachable on the include path.
*/
package mdts_pkg;
  `include "mdts_consts.svh"

  // ----------------------------------------------------------------------------
  // reference lock source choices
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    MDTS_REF_ONBOARD,
    MDTS_REF_BP_SLOW,
    MDTS_REF_BP_FAST,
    MDTS_REF_CABLE,
    MDTS_REF_MAIN_TB
  } mdts_ref_type;

  typedef enum logic [1:0] {
    MDTS_IDLE,
    MDTS_ARMED,
    MDTS_RUN
  } mdts_task_type;
endpackage : mdts_pkg

// file: core/mdts_divider.sv
/*
  clock-enable divider with a programmable period that restarts on sync.
  assumes: tick marks edges of the chosen timebase in the hclk domain.
*/
module mdts_divider #(
  parameter int WIDTH = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick,
  input wire logic sync,
  input wire logic run,
  input wire logic [WIDTH-1:0] period,
  output logic pulse
);
  logic [WIDTH-1:0] count;

  // ----------------------------------------------------------------------------
  // counting from a common restart
  // ----------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
      pulse <= 1'b0;
    end else if (sync || !run) begin
      count <= '0; // RULE8
      pulse <= 1'b0;
    end else if (tick) begin
      if (count + WIDTH'(1) >= period) begin
        count <= '0;
        pulse <= 1'b1;
      end else begin
        count <= count + WIDTH'(1);
        pulse <= 1'b0;
      end
    end else begin
      pulse <= 1'b0;
    end
  end
endmodule : mdts_divider

// file: bench/mdts_partner.sv
/*
  far-side model: other acquisition devices that emit reference, timebase,
  gate and sample ticks at fixed spacings, plus a start trigger on request.
  assumes: one hclk domain; ticks are one-cycle pulses changed after rising edges.
*/
module mdts_partner (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic trig_req,
  output logic [8:0] ticks,
  output logic trig
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------------------
  // tick spacings: onboard, slow, fast, cable, main, sample, shared, gate, ext
  // ----------------------------------------------------------------------------
  localparam logic [35:0] PER = {4'h5, 4'h6, 4'h2, 4'h3, 4'h4, 4'h5, 4'h2, 4'h7, 4'h3};
  logic [15:0] cnt;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 16'h0000;
      ticks <= 9'h000;
      trig <= 1'b0;
    end else begin
      cnt <= cnt + 16'h0001;
      for (int i = 0; i < 9; i++) begin
        ticks[i] <= ((cnt % PER[i*4 +: 4]) == (PER[i*4 +: 4] - 4'h1));
      end
      trig <= trig_req;
    end
  end
endmodule : mdts_partner

// file: bench/multi_device_timebase_sync_tb.sv
/*
  self-checking bench for the timebase synchronisation core.
  assumes: the core's constants header is on the include path; the partner
  model supplies all timebase ticks and the cabled start trigger.
*/
`include "mdts_consts.svh"
module multi_device_timebase_sync_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] src; logic [31:0] ctr; int pi; int mi; int ci; int ti;} mdts_row_type;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, trig_req = 1'b0, trig, rdy_q, pll_ref_tick, main_timebase_tick, sample_clock;
  logic counter_timebase, counter_sample_clock, start_trigger, trigger_out, pll_locked, task_running;
  logic [31:0] rd_q, d;
  logic [8:0] tk, v;
  int num_errors = 0, n_compared = 0, st_cnt = 0, c;
  mdts_row_type rows [6];
  always #4 hclk = ~hclk;
  always @(posedge hclk) begin
    rd_q <= hrdata;
    rdy_q <= hreadyout;
    if (start_trigger === 1'b1) st_cnt <= st_cnt + 1;
  end
  mdts_partner mdts_partner_i (.hclk(hclk), .hresetn(hresetn), .trig_req(trig_req), .ticks(tk), .trig(trig));
  mdts_core #(.LOCK_CYCLES(16'd4)) mdts_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .onboard_tick(tk[0]), .backplane_ref_clock_slow(tk[1]),
    .backplane_ref_clock_fast(tk[2]), .exported_reference_clock(tk[3]), .main_timebase_in(tk[4]),
    .sample_timebase_in(tk[5]), .fast_internal_timebase(tk[6]), .counter_gate_signal(tk[7]),
    .ext_sample_clock(tk[8]), .cable_trigger_bus(trig), .pll_ref_tick(pll_ref_tick),
    .main_timebase_tick(main_timebase_tick), .sample_clock(sample_clock), .counter_timebase(counter_timebase),
    .counter_sample_clock(counter_sample_clock), .start_trigger(start_trigger), .trigger_out(trigger_out),
    .pll_locked(pll_locked), .task_running(task_running));
  // ----------------------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------------------
  task automatic final_report;
    if (num_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic stuck;
    num_errors++;
    $display("mismatch at %0t: got %h expected %h", $time, 32'h0, 32'h1);
    final_report();
  endtask : stuck
  // ----------------------------------------------------------------------------
  // ahb-lite single word transfers
  // ----------------------------------------------------------------------------
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
    end while (rdy_q !== 1'b1 && n < 20);
    if (n >= 20) stuck();
  endtask : wait_rdy
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? wd : 32'h0;
    wait_rdy();
    rd = rd_q;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] x;
    xfer(1'b1, a, wd, x);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] x);
    xfer(1'b0, a, 32'h0, x);
  endtask : rd
  // ----------------------------------------------------------------------------
  // waits on design outputs
  // ----------------------------------------------------------------------------
  task automatic wait_start;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
    end while (start_trigger !== 1'b1 && n < 60);
    if (n >= 60) stuck();
  endtask : wait_start
  task automatic samp_period(output int cyc);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
    end while (sample_clock !== 1'b1 && n < 300);
    cyc = 0;
    do begin
      @(posedge hclk);
      #1;
      cyc++;
    end while (sample_clock !== 1'b1 && cyc < 300);
    if (n >= 300 || cyc >= 300) stuck();
  endtask : samp_period
  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    rows[0] = '{32'h00, 32'h0, 0, 0, 8, 15};
    rows[1] = '{32'h01, 32'h1, 1, 0, 15, 6};
    rows[2] = '{32'h02, 32'h2, 2, 0, 7, 15};
    rows[3] = '{32'h03, 32'h0, 3, 0, 8, 15};
    rows[4] = '{32'h14, 32'h3, 4, 4, 7, 6};
    rows[5] = '{32'h15, 32'h3, 4, 4, 7, 6};
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk(hreadyout, 1'b1);
    chk(hresp, 1'b0);
    chk({start_trigger, trigger_out, pll_locked, task_running, sample_clock}, 5'h00);
    rd(`MDTS_OFF_MAIN_RATE, d);
    chk(d, `MDTS_RST_MAIN_RATE);
    rd(`MDTS_OFF_SAMP_RATE, d);
    chk(d, `MDTS_RST_SAMP_RATE);
    rd(`MDTS_OFF_SAMP_DIV, d);
    chk(d, `MDTS_RST_SAMP_DIV);
    rd(`MDTS_OFF_STATUS, d);
    chk(d[1:0], 2'h0);
    rd(12'h01c, d);
    chk(d, 32'h0);
    foreach (rows[r]) begin
      wr(`MDTS_OFF_SRC, rows[r].src);
      wr(`MDTS_OFF_CTR_SEL, rows[r].ctr);
      repeat (3) @(posedge hclk);
      for (int k = 0; k < 16; k++) begin
        @(negedge hclk);
        v = tk;
        @(posedge hclk);
        #1;
        chk(pll_ref_tick, v[rows[r].pi]);
        chk(main_timebase_tick, v[rows[r].mi]);
        if (rows[r].ci < 9) chk(counter_sample_clock, v[rows[r].ci]);
        if (rows[r].ti < 9) chk(counter_timebase, v[rows[r].ti]);
      end
    end
    wr(`MDTS_OFF_SRC, 32'h22);
    c = 0;
    while (pll_locked !== 1'b1 && c < 100) begin
      @(posedge hclk);
      #1;
      c++;
    end
    chk(pll_locked, 1'b1);
    rd(`MDTS_OFF_STATUS, d);
    chk(d[2], 1'b1);
    wr(`MDTS_OFF_SAMP_RATE, 32'd12);
    wr(`MDTS_OFF_SAMP_DIV, 32'd3);
    wr(`MDTS_OFF_CTRL, 32'h05);
    wait_start();
    chk(trigger_out, 1'b1);
    @(posedge hclk);
    #1;
    chk(task_running, 1'b1);
    samp_period(c);
    chk(c, 32'd12);
    wr(`MDTS_OFF_SRC, 32'h00);
    rd(`MDTS_OFF_SRC, d);
    chk(d[5:0], 6'h22);
    rd(`MDTS_OFF_STATUS, d);
    chk(d[1:0], 2'h2);
    wr(`MDTS_OFF_CTRL, 32'h02);
    rd(`MDTS_OFF_STATUS, d);
    chk(d[1:0], 2'h0);
    wr(`MDTS_OFF_SRC, 32'h12);
    wr(`MDTS_OFF_MAIN_RATE, 32'd20);
    wr(`MDTS_OFF_SAMP_DIV, 32'd4);
    wr(`MDTS_OFF_CTRL, 32'h05);
    samp_period(c);
    chk(c, 32'd20);
    wr(`MDTS_OFF_CTRL, 32'h02);
    wr(`MDTS_OFF_CTRL, 32'h11);
    c = st_cnt;
    repeat (10) @(posedge hclk);
    #1;
    chk(st_cnt, c);
    rd(`MDTS_OFF_STATUS, d);
    chk(d[1:0], 2'h1);
    @(posedge hclk);
    trig_req <= 1'b1;
    @(posedge hclk);
    trig_req <= 1'b0;
    wait_start();
    chk(trigger_out, 1'b0);
    wr(`MDTS_OFF_CTRL, 32'h02);
    wr(`MDTS_OFF_SRC, 32'h01);
    wr(`MDTS_OFF_CTRL, 32'h0d);
    wait_start();
    chk(pll_ref_tick, 1'b1);
    chk(trigger_out, 1'b1);
    wr(`MDTS_OFF_CTRL, 32'h02);
    final_report();
  end
endmodule : multi_device_timebase_sync_tb
